// ==== logic/fifo_read_map.vh ====
// Purpose: constants for the fifo read output path
// Assumes: byte addresses on a 32-bit avalon-mm slave
// Notes: read width equals write width, so read depth is the write depth
//
// What this block does
// - fall-through on: first word after empty shows on read data unasked.
// - fall-through off: first word valid one cycle after first read.
// - fall-through only changes timing of first word after empty.
// - after the first read both modes behave the same.
// - output register adds one read cycle of latency to every read.
// - dual clock mode always uses the output register.
// - output register reset is synchronous; polarity selectable high or low.
// - an option sets how clock enable and output reset interact.
// - reset priority: asserted reset acts at the next clock edge.
// - enable priority: reset acts only when the clock enable is active.
// - read depth equals number of words readable at the read width.
// - single clock only; dual clock mode shares mclk and only forces the output register.
`ifndef FIFO_READ_MAP_VH
`define FIFO_READ_MAP_VH

`define FRP_OFS_CTRL 4'h0
`define FRP_OFS_STATUS 4'h4
`define FRP_OFS_DEPTH 4'h8

`define FRP_CTRL_FWFT 0
`define FRP_CTRL_OUTREG 1
`define FRP_CTRL_DUAL 2
`define FRP_CTRL_RST_HIGH 3
`define FRP_CTRL_CE_PRIO 4
`define FRP_CTRL_W 5
`define FRP_CTRL_RESET 5'h08

`define FRP_ST_EMPTY 0
`define FRP_ST_FULL 1
`define FRP_ST_PRIMED 2
`define FRP_ST_COUNT_LSB 8

`endif

// ==== logic/fifo_word_store.v ====
// Purpose: word array of the fifo
// Assumes: one clock; write is clocked, read address is looked up directly
// Notes: the read result is registered by the caller
`timescale 1ns/10ps
module fifo_word_store #(
   parameter DATA_W = 32,
   parameter ADDR_W = 9
) (
   input wire mclk,
   input wire wr_en,
   input wire [ADDR_W-1:0] wr_addr,
   input wire [DATA_W-1:0] wr_word,
   input wire [ADDR_W-1:0] rd_addr,
   output wire [DATA_W-1:0] rd_word
);
   reg [DATA_W-1:0] words [0:(1<<ADDR_W)-1];

   always @(posedge mclk) begin
      if (wr_en) begin
         words[wr_addr] <= wr_word;
      end
   end

   assign rd_word = words[rd_addr];
endmodule // fifo_word_store

// ==== logic/two_entry_buffer.v ====
// Purpose: two-entry buffer with valid and ready on both sides
// Assumes: one clock, asynchronous active-high reset
// Notes: in_ready is registered, so a stall costs no word
`timescale 1ns/10ps
module two_entry_buffer #(
   parameter DATA_W = 32
) (
   input wire mclk,
   input wire sys_rst,
   input wire in_valid,
   output reg in_ready,
   input wire [DATA_W-1:0] in_data,
   output wire out_valid,
   input wire out_ready,
   output wire [DATA_W-1:0] out_data
);
   reg [DATA_W-1:0] slot0;
   reg [DATA_W-1:0] slot1;
   reg [1:0] fill;
   reg [1:0] next_fill;
   wire push;
   wire pop;

   assign out_valid = (fill != 2'h0);
   assign out_data = slot0;
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;

   always @* begin
      next_fill = fill;
      if (push & ~pop) begin
         next_fill = fill + 2'h1;
      end else if (pop & ~push) begin
         next_fill = fill - 2'h1;
      end
   end

   always @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         fill <= 2'h0;
         in_ready <= 1'b0;
         slot0 <= {DATA_W{1'b0}};
         slot1 <= {DATA_W{1'b0}};
      end else begin
         fill <= next_fill;
         in_ready <= (next_fill != 2'h2);
         if (pop) begin
            slot0 <= (fill == 2'h2) ? slot1 : in_data;
         end else if (push && fill == 2'h0) begin
            slot0 <= in_data;
         end
         if (push && ((fill == 2'h1 && !pop) || (fill == 2'h2))) begin
            slot1 <= in_data;
         end
      end
   end
endmodule // two_entry_buffer

// ==== logic/fifo_read_output_path.v ====
// Purpose: fifo with configurable read output path and avalon-mm control
// Assumes: one clock mclk; user logic on both sides shares it
// Notes: dual clock mode only changes output register use here
//
// Added by the designer: the register offsets and register access over Avalon-MM.
`timescale 1ns/10ps
`include "fifo_read_map.vh"
module fifo_read_output_path #(
   parameter DATA_W = 32,
   parameter ADDR_W = 9,
   parameter [DATA_W-1:0] OUTREG_INIT = {DATA_W{1'b0}}
) (
   input wire mclk,
   input wire sys_rst,
   // write side
   input wire wr_valid,
   output wire wr_ready,
   input wire [DATA_W-1:0] wr_data,
   // read side
   input wire rd_en,
   output reg [DATA_W-1:0] rd_data,
   output reg rd_valid,
   output reg rd_empty,
   output reg wr_full,
   input wire outregce,
   input wire rstreg,
   // avalon-mm slave
   input wire [3:0] address,
   input wire read,
   input wire write,
   input wire [31:0] writedata,
   output reg [31:0] readdata,
   output reg waitrequest
);
   localparam [ADDR_W:0] DEPTH = {1'b1, {ADDR_W{1'b0}}};

   reg [`FRP_CTRL_W-1:0] ctrl;
   reg [ADDR_W-1:0] wr_ptr;
   reg [ADDR_W-1:0] rd_ptr;
   reg [ADDR_W:0] count;
   reg [ADDR_W:0] next_count;
   reg primed;
   reg [DATA_W-1:0] stage_data;
   reg stage_valid;
   wire buf_valid;
   wire [DATA_W-1:0] buf_data;
   wire [DATA_W-1:0] mem_word;
   wire mem_write;
   wire mem_empty;
   wire fwft;
   wire use_outreg;
   wire rst_level;
   wire reg_reset;
   wire auto_pop;
   wire user_pop;
   wire pop;

   // ---------------------------------------------------------------- config
   assign fwft = ctrl[`FRP_CTRL_FWFT];
   // dual clock mode forces the output register in the path
   assign use_outreg = ctrl[`FRP_CTRL_OUTREG] | ctrl[`FRP_CTRL_DUAL];
   assign rst_level = ctrl[`FRP_CTRL_RST_HIGH] ? rstreg : ~rstreg;
   // priority choice: rstreg wins outright, or needs outregce as well
   assign reg_reset = ctrl[`FRP_CTRL_CE_PRIO] ? (rst_level & outregce) : rst_level;

   // ---------------------------------------------------------------- write side
   two_entry_buffer #(
      .DATA_W(DATA_W)
   ) in_buf (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .in_valid(wr_valid),
      .in_ready(wr_ready),
      .in_data(wr_data),
      .out_valid(buf_valid),
      .out_ready(~wr_full),
      .out_data(buf_data)
   );

   assign mem_write = buf_valid & ~wr_full;

   fifo_word_store #(
      .DATA_W(DATA_W),
      .ADDR_W(ADDR_W)
   ) store (
      .mclk(mclk),
      .wr_en(mem_write),
      .wr_addr(wr_ptr),
      .wr_word(buf_data),
      .rd_addr(rd_ptr),
      .rd_word(mem_word)
   );

   // ---------------------------------------------------------------- read side
   assign mem_empty = (count == {(ADDR_W+1){1'b0}});
   // fall-through: fetch the first word after empty without a read
   assign auto_pop = fwft & ~primed & ~mem_empty;
   // once a word has been presented, reads act as in normal mode
   assign user_pop = rd_en & ~mem_empty & (primed | ~fwft);
   assign pop = auto_pop | user_pop;

   always @* begin
      next_count = count;
      if (mem_write & ~pop) begin
         next_count = count + {{ADDR_W{1'b0}}, 1'b1};
      end else if (pop & ~mem_write) begin
         next_count = count - {{ADDR_W{1'b0}}, 1'b1};
      end
   end

   always @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         wr_ptr <= {ADDR_W{1'b0}};
         rd_ptr <= {ADDR_W{1'b0}};
         count <= {(ADDR_W+1){1'b0}};
         wr_full <= 1'b0;
         rd_empty <= 1'b1;
         primed <= 1'b0;
      end else begin
         count <= next_count;
         wr_full <= (next_count == DEPTH);
         rd_empty <= (next_count == {(ADDR_W+1){1'b0}});
         if (mem_write) begin
            wr_ptr <= wr_ptr + {{(ADDR_W-1){1'b0}}, 1'b1};
         end
         if (pop) begin
            rd_ptr <= rd_ptr + {{(ADDR_W-1){1'b0}}, 1'b1};
         end
         // primed marks a presented word; it clears only on a read that finds memory empty
         if (auto_pop) begin
            primed <= 1'b1;
         end else if (rd_en && primed && mem_empty) begin
            primed <= 1'b0;
         end
      end
   end

   // first stage: one cycle after the pop
   always @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         stage_data <= {DATA_W{1'b0}};
         stage_valid <= 1'b0;
      end else begin
         stage_valid <= pop;
         if (pop) begin
            stage_data <= mem_word;
         end
      end
   end

   // single output flop serves both paths, so dout always comes from a flop
   always @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         rd_data <= {DATA_W{1'b0}};
         rd_valid <= 1'b0;
      end else if (reg_reset) begin
         rd_data <= OUTREG_INIT;
         rd_valid <= 1'b0;
      end else if (use_outreg) begin
         // extra stage: data two cycles after the pop
         rd_valid <= stage_valid & outregce;
         if (stage_valid && outregce) begin
            rd_data <= stage_data;
         end
      end else begin
         rd_valid <= pop;
         if (pop) begin
            rd_data <= mem_word;
         end
      end
   end

   // ---------------------------------------------------------------- avalon-mm
   // one wait cycle per access: answer in the cycle after the request is seen
   wire access;
   assign access = (read | write) & waitrequest;

   reg answered;

   always @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         waitrequest <= 1'b1;
         answered <= 1'b0;
         readdata <= 32'h0000_0000;
         ctrl <= `FRP_CTRL_RESET;
      end else begin
         if (access && !answered) begin
            waitrequest <= 1'b0;
            answered <= 1'b1;
            case (address)
               `FRP_OFS_CTRL: begin
                  readdata <= {{(32-`FRP_CTRL_W){1'b0}}, ctrl};
               end
               `FRP_OFS_STATUS: begin
                  readdata <= 32'h0000_0000;
                  readdata[`FRP_ST_EMPTY] <= rd_empty;
                  readdata[`FRP_ST_FULL] <= wr_full;
                  readdata[`FRP_ST_PRIMED] <= primed;
                  readdata[`FRP_ST_COUNT_LSB +: ADDR_W+1] <= count;
               end
               `FRP_OFS_DEPTH: begin
                  readdata <= {{(31-ADDR_W){1'b0}}, DEPTH};
               end
               default: begin
                  readdata <= 32'h0000_0000;
               end
            endcase
         end else begin
            waitrequest <= 1'b1;
            answered <= 1'b0;
         end
         // write lands at the edge where the master sees waitrequest low
         if (write && !waitrequest && address == `FRP_OFS_CTRL) begin
            ctrl <= writedata[`FRP_CTRL_W-1:0];
         end
      end
   end
endmodule // fifo_read_output_path

// ==== testbench/fifo_read_output_path_asserts.sv ====
// Purpose: port-level checks of the fifo read output path
// Assumes: one clock; control options shadowed from avalon writes
// Notes: ctrl writes are made only while the read side is idle
`timescale 1ns/10ps
module fifo_read_output_path_asserts #(
   parameter DATA_W = 32,
   parameter ADDR_W = 9,
   parameter [DATA_W-1:0] OUTREG_INIT = {DATA_W{1'b0}}
) (
   input wire mclk,
   input wire sys_rst,
   input wire rd_en,
   input wire [DATA_W-1:0] rd_data,
   input wire rd_valid,
   input wire rd_empty,
   input wire outregce,
   input wire rstreg,
   input wire [3:0] address,
   input wire read,
   input wire write,
   input wire [31:0] writedata,
   input wire [31:0] readdata,
   input wire waitrequest
);
   reg [4:0] ctrl;
   wire hit = (rstreg == ctrl[3]);
   wire take = !ctrl[0] && rd_en && !rd_empty;
   always @(posedge mclk or posedge sys_rst)
      if (sys_rst)
         ctrl <= 5'h08;
      else if (write && !waitrequest && address == 4'h0)
         ctrl <= writedata[4:0];
   default clocking cb @(posedge mclk); endclocking
   default disable iff (sys_rst);
   a_wait_answer: assert property ((read || write) && waitrequest |=> !waitrequest)
      else $error("no bus answer");
   a_wait_pulse: assert property (!waitrequest |=> waitrequest)
      else $error("waitrequest low too long");
   a_read_hold: assert property (waitrequest && $past(waitrequest) |-> $stable(readdata))
      else $error("readdata moved while idle");
   a_unmapped_zero: assert property (read && waitrequest && address > 4'h8 |=> readdata == 32'h0)
      else $error("unmapped read not zero");
   a_depth_value: assert property (read && waitrequest && address == 4'h8 |=> readdata == (1 << ADDR_W))
      else $error("depth wrong");
   a_rst_prio: assert property (hit && !ctrl[4] |=> rd_data == OUTREG_INIT && !rd_valid)
      else $error("reset priority failed");
   a_ce_prio: assert property (hit && ctrl[4] && outregce |=> rd_data == OUTREG_INIT && !rd_valid)
      else $error("enable priority failed");
   a_norm_latency: assert property (take && !ctrl[1] && !ctrl[2] && !hit |=> rd_valid)
      else $error("read not one cycle");
   a_outreg_latency: assert property (take && (ctrl[1] || ctrl[2]) ##1 outregce && !hit |=> rd_valid)
      else $error("output register latency wrong");
endmodule // fifo_read_output_path_asserts
bind fifo_read_output_path fifo_read_output_path_asserts #(.DATA_W(DATA_W), .ADDR_W(ADDR_W),
   .OUTREG_INIT(OUTREG_INIT)) fifo_read_output_path_asserts_i (.mclk(mclk), .sys_rst(sys_rst),
   .rd_en(rd_en), .rd_data(rd_data), .rd_valid(rd_valid), .rd_empty(rd_empty), .outregce(outregce),
   .rstreg(rstreg), .address(address), .read(read), .write(write), .writedata(writedata),
   .readdata(readdata), .waitrequest(waitrequest));

// ==== testbench/fifo_writer_model.sv ====
// Purpose: user logic writing words into the fifo
// Assumes: word held until an edge samples wr_ready high
// Notes: idle data is the inverse of the last word, never stale
`timescale 1ns/10ps
module fifo_writer_model #(
   parameter DATA_W = 32
) (
   input wire mclk,
   input wire wr_ready,
   output reg wr_valid,
   output reg [DATA_W-1:0] wr_data
);
   initial begin
      wr_valid = 1'b0;
      wr_data = {DATA_W{1'b0}};
   end
   task send(input [DATA_W-1:0] w);
      begin
         @(posedge mclk);
         wr_valid <= 1'b1;
         wr_data <= w;
         @(posedge mclk);
         while (!wr_ready) @(posedge mclk);
         wr_valid <= 1'b0;
         wr_data <= ~w;
      end
   endtask
endmodule // fifo_writer_model

// ==== testbench/test_fifo_read_output_path.sv ====
// Purpose: self-checking bench for the fifo read output path
// Assumes: depth 4 words plus two held in the input buffer
// Notes: outputs sampled 1 ns after the edge, except readdata and the final rd_empty check, sampled at the edge
`timescale 1ns/10ps
module test_fifo_read_output_path;
   localparam [31:0] INIT = 32'h00005A5A;
   reg mclk = 1'b0, sys_rst = 1'b1, rd_en = 1'b0, outregce = 1'b1, rstreg = 1'b0;
   reg read = 1'b0, write = 1'b0;
   reg [3:0] address = 4'h0;
   reg [31:0] writedata = 32'h0, q;
   wire wr_valid, wr_ready, rd_valid, rd_empty, wr_full, waitrequest;
   wire [31:0] wr_data, rd_data, readdata;
   integer fails = 0, check_count = 0, i, n;
   always #25 mclk = ~mclk;
   fifo_read_output_path #(.ADDR_W(2), .OUTREG_INIT(INIT)) fifo_read_output_path_i (
      .mclk(mclk), .sys_rst(sys_rst), .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_data(wr_data),
      .rd_en(rd_en), .rd_data(rd_data), .rd_valid(rd_valid), .rd_empty(rd_empty), .wr_full(wr_full),
      .outregce(outregce), .rstreg(rstreg), .address(address), .read(read), .write(write),
      .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest));
   fifo_writer_model fifo_writer_model_i (.mclk(mclk), .wr_ready(wr_ready),
      .wr_valid(wr_valid), .wr_data(wr_data));
   task chk(input [31:0] got, input [31:0] exp);
      begin
         check_count = check_count + 1;
         if (got !== exp) begin
            fails = fails + 1;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask
   task ticks(input integer k);
      begin
         repeat (k) @(posedge mclk);
         #1;
      end
   endtask
   task av(input w, input [3:0] a, input [31:0] d);
      begin
         @(posedge mclk);
         address <= a;
         writedata <= d;
         read <= !w;
         write <= w;
         @(posedge mclk);
         while (waitrequest) @(posedge mclk);
         q = readdata;
         read <= 1'b0;
         write <= 1'b0;
      end
   endtask
   // one read request, returns just after the edge that takes it, while rd_valid stands if the output register is off
   task pull;
      begin
         @(posedge mclk);
         rd_en <= 1'b1;
         @(posedge mclk);
         rd_en <= 1'b0;
         #1;
      end
   endtask
   task t_regs;
      begin
         av(0, 4'h0, 0);
         chk(q, 32'h08);
         av(0, 4'h4, 0);
         chk(q, 32'h01);
         av(1, 4'h8, 32'hFF);
         av(0, 4'h8, 0);
         chk(q, 32'h04);
         av(0, 4'hC, 0);
         chk(q, 32'h0);
      end
   endtask
   task t_normal;
      begin
         fifo_writer_model_i.send(32'hC1);
         ticks(6);
         chk(rd_data, 32'h0);
         pull;
         chk(rd_valid, 1);
         chk(rd_data, 32'hC1);
      end
   endtask
   task t_outreg;
      for (i = 0; i < 2; i = i + 1) begin
         av(1, 4'h0, i ? 32'h0C : 32'h0A);
         fifo_writer_model_i.send(32'hD0 + i);
         ticks(6);
         pull;
         chk(rd_valid, 0);
         ticks(1);
         chk(rd_valid, 1);
         chk(rd_data, 32'hD0 + i);
      end
   endtask
   // fill memory and buffer until refused, then drain back to back
   task t_fill;
      begin
         av(1, 4'h0, 32'h08);
         for (i = 0; i < 6; i = i + 1)
            fifo_writer_model_i.send(32'h10 + i);
         ticks(4);
         chk(wr_full, 1);
         chk(wr_ready, 0);
         av(0, 4'h4, 0);
         chk(q, 32'h402);
         n = 0;
         @(posedge mclk);
         rd_en <= 1'b1;
         repeat (20) begin
            ticks(1);
            if (rd_valid === 1'b1) begin
               chk(rd_data, 32'h10 + n);
               n = n + 1;
            end
         end
         @(posedge mclk);
         rd_en <= 1'b0;
         chk(n, 6);
         chk(rd_empty, 1);
      end
   endtask
   task t_rst;
      begin
         av(1, 4'h0, 32'h18);
         @(posedge mclk);
         outregce <= 1'b0;
         rstreg <= 1'b1;
         ticks(2);
         chk(rd_data, 32'h15);
         @(posedge mclk);
         outregce <= 1'b1;
         ticks(1);
         chk(rd_data, INIT);
         av(1, 4'h0, 32'h00);
         fifo_writer_model_i.send(32'hE0);
         ticks(6);
         pull;
         chk(rd_data, 32'hE0);
         @(posedge mclk);
         rstreg <= 1'b0;
         ticks(1);
         chk(rd_data, INIT);
         av(1, 4'h0, 32'h08);
      end
   endtask
   task t_fwft;
      begin
         av(1, 4'h0, 32'h09);
         fifo_writer_model_i.send(32'hA0);
         ticks(8);
         chk(rd_data, 32'hA0);
         av(0, 4'h4, 0);
         chk(q, 32'h05);
         fifo_writer_model_i.send(32'hB0);
         ticks(6);
         chk(rd_data, 32'hA0);
         pull;
         chk(rd_data, 32'hB0);
         chk(rd_valid, 1);
      end
   endtask
   task test_done;
      begin
         $display("checks %0d mismatches %0d", check_count, fails);
         if (fails == 0 && check_count > 0)
            $display("Finished cleanly");
         else
            $display("Finished with errors");
         $finish;
      end
   endtask
   initial begin
      repeat (3) @(posedge mclk);
      sys_rst <= 1'b0;
      t_regs;
      t_normal;
      t_outreg;
      t_fill;
      t_rst;
      t_fwft;
      test_done;
   end
   initial begin
      repeat (4000) @(posedge mclk);
      fails = fails + 1;
      test_done;
   end
endmodule // test_fifo_read_output_path
